// ===== rtl/seq_ctrl_pkg.sv
package seq_ctrl_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          CODE_W          = 4;
    localparam int          CHAN_N          = 4;
    localparam logic [7:0]  STATE_CTRL_ADDR = 8'h27;
    localparam logic [3:0]  CODE_RESET      = 4'h0;
    localparam logic [3:0]  FLAGS_RESET     = 4'h0;
    localparam int          CODE_LSB        = 0;

    // ----------------------------------------------------------------
    // window select encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  WIN_STATE1      = 2'h0;
    localparam logic [1:0]  WIN_STATE2      = 2'h1;
    localparam logic [1:0]  WIN_STATE3      = 2'h2;
    localparam logic [1:0]  WIN_FLAGS       = 2'h3;

    // ----------------------------------------------------------------
    // sequencer state codes as seen on the state output
    // ----------------------------------------------------------------
    localparam logic [2:0]  STATE_IDLE_CODE  = 3'h0;
    localparam logic [2:0]  STATE1_CODE      = 3'h1;
    localparam logic [2:0]  STATE2_CODE      = 3'h2;
    localparam logic [2:0]  STATE3_CODE      = 3'h3;
    localparam logic [2:0]  STATE_FINAL_CODE = 3'h4;

    typedef enum logic [2:0] {
        seq_idle,
        seq_state1,
        seq_state2,
        seq_state3,
        seq_final
    } seq_state_type;

    // destination of a single channel hit
    typedef enum logic [2:0] {
        dest_none,
        dest_s1,
        dest_s2,
        dest_s3,
        dest_fin
    } dest_type;

endpackage

// ===== rtl/debug_state_sequencer_control.sv
// How it works
// - one address, window field picks register
// - writes only when selected and disarmed
// - reads return register only when selected
// - state1 codes 0-2: any match moves
// - state1 codes 3-5: only channel 2
// - state1 codes 6,8,A: two-channel to s2/s3
// - state1 codes 7,9,B: s3 or final
// - state1 code C: 0-2 to s2; reserved do nothing
// - state2 codes 0-2: any match moves
// - state2 codes 3-5: only channel 3
// - state2 codes 6,8,A: to s1/s3
// - state2 codes 7,9,B: s3 or final
// - state2 codes C,D special; E,F do nothing
// - state3 codes 0-2: any match moves
// - state3 single-channel codes per table
// - state3 dual codes; E,F do nothing
// - lowest channel wins among simultaneous hits
// - final-state hit beats all others
// - only enabled comparators produce hits
// - one sticky flag per channel, kept after
// - flags read-only, cleared only by arming
// - flags set independently, stay set
`timescale 1ns/1ps
module debug_state_sequencer_control
(
    // clock and reset
    input  wire logic                               ref_clk,
    input  wire logic                               rst_b,
    // register port
    input  wire logic [seq_ctrl_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [seq_ctrl_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [seq_ctrl_pkg::DATA_W-1:0]    reg_rdata,
    // debug control side
    input  wire logic [1:0]                         window_select_field,
    input  wire logic                               armed,
    input  wire logic                               arm_write,
    // comparator channels
    input  wire logic [seq_ctrl_pkg::CHAN_N-1:0]    match_hit,
    input  wire logic [seq_ctrl_pkg::CHAN_N-1:0]    comparator_enable,
    // sequencer status
    output logic      [2:0]                         sequencer_state,
    output logic                                    final_reached
);
    import seq_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // overview
    // ----------------------------------------------------------------
    // three codes and four flags share
    // one byte address; the window field
    // steers each access to one of them
    // software sets the window first
    // the sequencer moves only while armed
    // and waits in idle when disarmed
    // raw matches are gated by their
    // enables here, so a disabled
    // comparator leaves no trace
    // a final hit beats all others, then
    // the lowest channel that counts
    // arming and the enables are owned
    // outside this block
    // everything runs on ref_clk and
    // rst_b alone

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // next-state code per state
    logic [CODE_W-1:0]  state1_transition_select;
    logic [CODE_W-1:0]  state2_transition_select;
    logic [CODE_W-1:0]  state3_transition_select;
    // sticky hit record
    logic [CHAN_N-1:0]  channel_hit_flags;
    // sequencer state
    seq_state_type      seq_state;
    seq_state_type      next_seq_state;
    // gated hits and decode
    logic [CHAN_N-1:0]  live_hit;
    logic               addr_hit;

    // ----------------------------------------------------------------
    // per-channel destination tables
    // ----------------------------------------------------------------
    // state1 table; reserved codes fall to the default
    // answers for one channel per call
    // so the caller can rank channels
    // codes 0-2 take any channel; the
    // rest name the channels that count
    function automatic dest_type dest_from_s1(input logic [3:0] code, input int ch);
        dest_type d;
        d = dest_none;
        unique case (code)
            4'h0: d = dest_s2;
            4'h1: d = dest_s3;
            4'h2: d = dest_fin;
            4'h3: d = (ch == 2) ? dest_s2 : dest_none;
            4'h4: d = (ch == 2) ? dest_s3 : dest_none;
            4'h5: d = (ch == 2) ? dest_fin : dest_none;
            4'h6: d = (ch == 0) ? dest_s2 : (ch == 1) ? dest_s3 : dest_none;
            4'h7: d = (ch == 1) ? dest_s3 : (ch == 0) ? dest_fin : dest_none;
            4'h8: d = (ch == 0) ? dest_s2 : (ch == 2) ? dest_s3 : dest_none;
            4'h9: d = (ch == 2) ? dest_s3 : (ch == 0) ? dest_fin : dest_none;
            4'hA: d = (ch == 1) ? dest_s2 : (ch == 3) ? dest_s3 : dest_none;
            4'hB: d = (ch == 3) ? dest_s3 : (ch == 1) ? dest_fin : dest_none;
            4'hC: d = (ch != 3) ? dest_s2 : dest_none;
            default: d = dest_none;
        endcase
        return d;
    endfunction

    // state2 table
    // same scheme as state1; code C mixes
    // final with state1; D is final only
    // codes E and F never move
    // channels not named are ignored
    function automatic dest_type dest_from_s2(input logic [3:0] code, input int ch);
        dest_type d;
        d = dest_none;
        unique case (code)
            4'h0: d = dest_s1;
            4'h1: d = dest_s3;
            4'h2: d = dest_fin;
            4'h3: d = (ch == 3) ? dest_s1 : dest_none;
            4'h4: d = (ch == 3) ? dest_s3 : dest_none;
            4'h5: d = (ch == 3) ? dest_fin : dest_none;
            4'h6: d = (ch == 0) ? dest_s1 : (ch == 1) ? dest_s3 : dest_none;
            4'h7: d = (ch == 1) ? dest_s3 : (ch == 0) ? dest_fin : dest_none;
            4'h8: d = (ch == 0) ? dest_s1 : (ch == 2) ? dest_s3 : dest_none;
            4'h9: d = (ch == 2) ? dest_s3 : (ch == 0) ? dest_fin : dest_none;
            4'hA: d = (ch == 1) ? dest_s1 : (ch == 3) ? dest_s3 : dest_none;
            4'hB: d = (ch == 3) ? dest_s3 : (ch == 1) ? dest_fin : dest_none;
            4'hC: d = (ch == 2) ? dest_s1 : (ch == 3) ? dest_fin : dest_none;
            4'hD: d = (ch != 2) ? dest_fin : dest_none;
            default: d = dest_none;
        endcase
        return d;
    endfunction

    // state3 table
    // most codes here name one channel
    // only; dual codes 5, 9 and B pair a final
    // move with state1 or 2; A pairs state1 with 2
    // codes E and F never move
    function automatic dest_type dest_from_s3(input logic [3:0] code, input int ch);
        dest_type d;
        d = dest_none;
        unique case (code)
            4'h0: d = dest_s1;
            4'h1: d = dest_s2;
            4'h2: d = dest_fin;
            4'h3: d = (ch == 0) ? dest_s1 : dest_none;
            4'h4: d = (ch == 0) ? dest_s2 : dest_none;
            4'h5: d = (ch == 0) ? dest_fin : (ch == 1) ? dest_s1 : dest_none;
            4'h6: d = (ch == 1) ? dest_s1 : dest_none;
            4'h7: d = (ch == 1) ? dest_s2 : dest_none;
            4'h8: d = (ch == 1) ? dest_fin : dest_none;
            4'h9: d = (ch == 2) ? dest_s2 : (ch == 0) ? dest_fin : dest_none;
            4'hA: d = (ch == 1) ? dest_s1 : (ch == 3) ? dest_s2 : dest_none;
            4'hB: d = (ch == 3) ? dest_s2 : (ch == 1) ? dest_fin : dest_none;
            4'hC: d = (ch == 2) ? dest_fin : dest_none;
            4'hD: d = (ch == 3) ? dest_fin : dest_none;
            default: d = dest_none;
        endcase
        return d;
    endfunction

    // maps a destination to the sequencer state enum
    // none maps to idle but is never
    // used as a next state
    function automatic seq_state_type dest_to_state(input dest_type d);
        seq_state_type s;
        s = seq_idle;
        unique case (d)
            dest_s1:   s = seq_state1;
            dest_s2:   s = seq_state2;
            dest_s3:   s = seq_state3;
            dest_fin:  s = seq_final;
            dest_none: s = seq_idle;
        endcase
        return s;
    endfunction

    // ----------------------------------------------------------------
    // hit gating and bus decode
    // ----------------------------------------------------------------
    // disabled comparators must never steer the sequencer or set flags
    assign live_hit = match_hit & comparator_enable;
    // one decode serves writes and reads
    // so both see the same address
    assign addr_hit = (reg_addr == STATE_CTRL_ADDR);

    // ----------------------------------------------------------------
    // next state selection
    // ----------------------------------------------------------------
    // final wins first, then lowest channel; scanning downward lets
    // the lower channel overwrite a higher one of the same class
    // arming restarts in state1, even
    // from final; losing armed drops to
    // idle whatever hits are pending
    // idle and final look up no code
    always_comb
    begin
        dest_type      d;
        dest_type      best;
        dest_type      best_fin;
        logic [3:0]    code;
        d        = dest_none;
        best     = dest_none;
        best_fin = dest_none;
        code     = state1_transition_select;
        // code of the current state
        unique case (seq_state)
            seq_state1: code = state1_transition_select;
            seq_state2: code = state2_transition_select;
            seq_state3: code = state3_transition_select;
            seq_idle:   code = state1_transition_select;
            seq_final:  code = state1_transition_select;
        endcase
        // rank every channel, high to low
        for (int ch = CHAN_N - 1; ch >= 0; ch--)
        begin
            unique case (seq_state)
                seq_state1: d = dest_from_s1(code, ch);
                seq_state2: d = dest_from_s2(code, ch);
                seq_state3: d = dest_from_s3(code, ch);
                seq_idle:   d = dest_none;
                seq_final:  d = dest_none;
            endcase
            // only enabled hits that move
            if (live_hit[ch] && d != dest_none)
            begin
                best = d;
                if (d == dest_fin)
                    best_fin = d;
            end
        end
        if (best_fin != dest_none)
            best = best_fin;
        // hold unless arm, disarm or hit
        next_seq_state = seq_state;
        if (arm_write)
            next_seq_state = seq_state1;
        else if (!armed)
            next_seq_state = seq_idle;
        else if (best != dest_none)
            next_seq_state = dest_to_state(best);
    end

    // ----------------------------------------------------------------
    // sequencer state and outputs
    // ----------------------------------------------------------------
    // final is sticky until disarm or a fresh arm
    // kept as an enum; the port shows
    // the package codes instead
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            seq_state <= seq_idle;
        else
            seq_state <= next_seq_state;
    end

    // state code and one-cycle pulse on entering final
    // both come from the next state so
    // they line up with the state flop
    // the pulse stays low while final
    // is held
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sequencer_state <= STATE_IDLE_CODE;
            final_reached   <= 1'b0;
        end
        else
        begin
            final_reached <= (next_seq_state == seq_final) && (seq_state != seq_final);
            unique case (next_seq_state)
                seq_idle:   sequencer_state <= STATE_IDLE_CODE;
                seq_state1: sequencer_state <= STATE1_CODE;
                seq_state2: sequencer_state <= STATE2_CODE;
                seq_state3: sequencer_state <= STATE3_CODE;
                seq_final:  sequencer_state <= STATE_FINAL_CODE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // transition registers
    // ----------------------------------------------------------------
    // armed write lock keeps the table stable during a session
    // a write in the flags window has
    // no target: flags are read-only
    // bits 7:4 of the data are dropped
    // limitation: a write while armed
    // is lost without any indication;
    // software must disarm first
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state1_transition_select <= CODE_RESET;
            state2_transition_select <= CODE_RESET;
            state3_transition_select <= CODE_RESET;
        end
        else if (reg_wr && addr_hit && !armed)
        begin
            unique case (window_select_field)
                WIN_STATE1: state1_transition_select <= reg_wdata[CODE_LSB +: CODE_W];
                WIN_STATE2: state2_transition_select <= reg_wdata[CODE_LSB +: CODE_W];
                WIN_STATE3: state3_transition_select <= reg_wdata[CODE_LSB +: CODE_W];
                WIN_FLAGS:  ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // match flags
    // ----------------------------------------------------------------
    // set beats the arming clear so a hit in that cycle is kept
    // channels are handled one by one,
    // so a set flag never blocks another
    // a set flag stays set on more hits
    // hits outside a session are dropped
    // and disarming keeps the record
    // arming clears all but hit ones
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            channel_hit_flags <= FLAGS_RESET;
        else
        begin
            for (int ch = 0; ch < CHAN_N; ch++)
            begin
                if (armed && live_hit[ch])
                    channel_hit_flags[ch] <= 1'b1;
                else if (arm_write)
                    channel_hit_flags[ch] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // one-cycle read latency; upper bits and other addresses read zero
    // the answer stands one cycle only;
    // zero elsewhere keeps a stale value
    // from passing for a fresh answer
    // the window is taken with the strobe
    // so a later change cannot disturb it
    // other addresses also read zero
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= '0;
        else
        begin
            reg_rdata <= '0;
            if (reg_rd && addr_hit)
            begin
                unique case (window_select_field)
                    WIN_STATE1: reg_rdata[CODE_LSB +: CODE_W] <= state1_transition_select;
                    WIN_STATE2: reg_rdata[CODE_LSB +: CODE_W] <= state2_transition_select;
                    WIN_STATE3: reg_rdata[CODE_LSB +: CODE_W] <= state3_transition_select;
                    WIN_FLAGS:  reg_rdata[CHAN_N-1:0]          <= channel_hit_flags;
                endcase
            end
        end
    end

endmodule

// ===== verification/seq_ctrl_monitor.sv
`timescale 1ns/1ps
module seq_ctrl_monitor
    import seq_ctrl_pkg::*;
(
    input wire logic                            ref_clk,
    input wire logic                            rst_b,
    input wire logic [seq_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [seq_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                            reg_wr,
    input wire logic                            reg_rd,
    input wire logic [seq_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [1:0]                      window_select_field,
    input wire logic                            armed,
    input wire logic                            arm_write,
    input wire logic [seq_ctrl_pkg::CHAN_N-1:0] match_hit,
    input wire logic [seq_ctrl_pkg::CHAN_N-1:0] comparator_enable,
    input wire logic [2:0]                      sequencer_state,
    input wire logic                            final_reached
);
    logic [3:0] gated;
    logic [3:0] code [3];
    logic       go;
    logic       sel;
    logic       s1;
    logic       s2;
    assign gated = match_hit & comparator_enable;
    assign go = armed && !arm_write;
    assign sel = reg_addr == STATE_CTRL_ADDR;
    assign s1 = sequencer_state == STATE1_CODE;
    assign s2 = sequencer_state == STATE2_CODE;

    // shadow of the codes, so that transitions can be judged from the ports
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            code <= '{default: CODE_RESET};
        else if (reg_wr && sel && !armed && window_select_field != WIN_FLAGS)
            code[window_select_field] <= reg_wdata[3:0];
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_code_read: assert property (reg_rd && sel && window_select_field != WIN_FLAGS
        |=> reg_rdata == {4'h0, $past(code[window_select_field])}) else $error("bad code read");
    a_any_final: assert property (go && s1 && code[0] == 4'h2 && gated != 0
        |=> sequencer_state == STATE_FINAL_CODE) else $error("no move to final");
    a_ch2_only: assert property (go && s1 && code[0] inside {4'h3, 4'h4, 4'h5}
        && !gated[2] |=> $stable(sequencer_state)) else $error("moved without channel 2");
    a_lowest_wins: assert property (go && s1 && code[0] == 4'h6 && gated[1:0] == 2'b11
        |=> sequencer_state == STATE2_CODE) else $error("lowest channel lost");
    a_final_wins: assert property (go && s2 && code[1] == 4'h7 && gated[1:0] == 2'b11
        |=> sequencer_state == STATE_FINAL_CODE) else $error("final hit lost");
    a_no_hit_hold: assert property (go && sequencer_state inside {3'h1, 3'h2, 3'h3}
        && gated == 4'h0 |=> $stable(sequencer_state)) else $error("moved without hit");
    a_flag_sticky: assert property ((armed && gated != 0) ##1 (reg_rd && sel
        && window_select_field == WIN_FLAGS) |=> (reg_rdata[3:0] & $past(gated, 2))
        == $past(gated, 2)) else $error("flag not set");
    a_arm_clear: assert property ((arm_write && armed && gated == 0) ##1 (reg_rd && sel
        && window_select_field == WIN_FLAGS) |=> reg_rdata[3:0] == 4'h0)
        else $error("flags not cleared by arming");
    a_final_pulse: assert property (final_reached |->
        sequencer_state == STATE_FINAL_CODE && $past(sequencer_state) != STATE_FINAL_CODE)
        else $error("final pulse out of place");
endmodule

bind debug_state_sequencer_control seq_ctrl_monitor mon_u (.ref_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .window_select_field, .armed, .arm_write,
    .match_hit, .comparator_enable, .sequencer_state, .final_reached);

// ===== verification/comparator_channels.sv
`timescale 1ns/1ps
module comparator_channels
    import seq_ctrl_pkg::*;
(
    input  wire logic                            ref_clk,
    input  wire logic                            rst_b,
    input  wire logic [1:0]                      hit_rate,
    output logic      [seq_ctrl_pkg::CHAN_N-1:0] match_hit
);
    // match bits are redrawn every cycle; rate 0 keeps every channel silent
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            match_hit <= 4'h0;
        else if (hit_rate == 2'h0)
            match_hit <= 4'h0;
        else
            match_hit <= hit_rate[1] ? 4'($urandom) : 4'($urandom) & 4'($urandom);
    end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import seq_ctrl_pkg::*;
    // next-state tables, one nibble per channel, code 0 in the low word
    localparam logic [255:0] t1 = {128'h0000_0000_0000_0222_3040_3020_0304_0302,
        128'h0034_0032_0400_0300_0200_4444_3333_2222};
    localparam logic [255:0] t2 = {128'h0000_0000_4044_4100_3040_3010_0304_0301,
        128'h0034_0031_4000_3000_1000_4444_3333_1111};
    localparam logic [255:0] t3 = {128'h0000_0000_4000_0400_2040_2010_0204_0040,
        128'h0020_0010_0014_0002_0001_4444_2222_1111};
    logic       ref_clk, rst_b, reg_wr, reg_rd, armed, arm_write, final_reached;
    logic       exp_final, live;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_rdata;
    logic [1:0] window_select_field, hit_rate;
    logic [3:0] match_hit, comparator_enable, hit, exp_flags;
    logic [3:0] exp_code [3];
    logic [2:0] sequencer_state, exp_state, nxt;
    int         bad_count, tests_run, cycles;

    debug_state_sequencer_control dut_u (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .window_select_field, .armed, .arm_write, .match_hit,
        .comparator_enable, .sequencer_state, .final_reached);
    comparator_channels chan_u (.ref_clk, .rst_b, .hit_rate, .match_hit);

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // final hits win, otherwise the lowest channel with a destination
    function automatic logic [2:0] next_of(input logic [2:0] st, input logic [3:0] code,
                                           input logic [3:0] h);
        logic [15:0] row;
        logic [2:0]  mv;
        logic        fin;
        row = (st == 3'h1) ? t1[code*16 +: 16] : (st == 3'h2) ? t2[code*16 +: 16]
            : t3[code*16 +: 16];
        mv = st;
        fin = 1'b0;
        for (int c = 3; c >= 0; c--)
            if (h[c] && row[c*4 +: 3] != 3'h0)
            begin
                mv = row[c*4 +: 3];
                fin = fin || mv == 3'h4;
            end
        return fin ? 3'h4 : mv;
    endfunction

    // reference model, sampling the same edge as the design
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {exp_state, exp_final, exp_flags, exp_rdata} <= '0;
            exp_code <= '{default: 4'h0};
        end
        else
        begin
            hit = match_hit & comparator_enable;
            nxt = arm_write ? 3'h1 : !armed ? 3'h0 : exp_state inside {3'h1, 3'h2, 3'h3}
                ? next_of(exp_state, exp_code[2'(exp_state - 3'h1)], hit)
                : exp_state;
            exp_final <= nxt == 3'h4 && exp_state != 3'h4;
            exp_state <= nxt;
            if (armed)
                exp_flags <= (arm_write ? 4'h0 : exp_flags) | hit;
            if (reg_wr && reg_addr == STATE_CTRL_ADDR && !armed
                && window_select_field != WIN_FLAGS)
                exp_code[window_select_field] <= reg_wdata[3:0];
            exp_rdata <= !(reg_rd && reg_addr == STATE_CTRL_ADDR) ? 8'h00 : {4'h0,
                window_select_field == WIN_FLAGS ? exp_flags : exp_code[window_select_field]};
        end
    end

    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    always @(negedge ref_clk)
        if (rst_b)
        begin
            check("reg_rdata", exp_rdata, reg_rdata);
            check("sequencer_state", 8'(exp_state), 8'(sequencer_state));
            check("final_reached", 8'(exp_final), 8'(final_reached));
        end

    // enables drop now and then so that ungated matches must be ignored
    always @(posedge ref_clk)
        comparator_enable <= (live && $urandom % 4 == 0) ? 4'($urandom) : 4'hf;

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task wr(input logic [1:0] w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        window_select_field <= w;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // also ends an arming pulse, so a read may follow it at once
    task rd(input logic [1:0] w, input logic [7:0] a);
        @(posedge ref_clk);
        arm_write <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        window_select_field <= w;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'he10e));
        {rst_b, reg_wr, reg_rd, armed, arm_write, live, hit_rate} = '0;
        {reg_addr, reg_wdata, window_select_field} = '0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 48; i++)
        begin
            wr(WIN_STATE1, STATE_CTRL_ADDR, {4'($urandom), 4'(i)});
            wr(WIN_STATE2, STATE_CTRL_ADDR, {4'($urandom), 4'(i * 7)});
            wr(WIN_STATE3, STATE_CTRL_ADDR, {4'($urandom), 4'(i * 11)});
            wr(WIN_FLAGS, STATE_CTRL_ADDR, 8'($urandom));
            wr(2'($urandom), 8'h26, 8'($urandom));
            for (int w = 0; w < 4; w++)
                rd(2'(w), STATE_CTRL_ADDR);
            rd(2'($urandom), 8'h28);
            @(posedge ref_clk);
            armed <= 1'b1;
            arm_write <= 1'b1;
            rd(WIN_FLAGS, STATE_CTRL_ADDR);
            hit_rate <= 2'($urandom % 3 + 1);
            live <= 1'b1;
            repeat (3)
            begin
                wr(2'($urandom), STATE_CTRL_ADDR, 8'($urandom));
                rd(2'($urandom), STATE_CTRL_ADDR);
                repeat (4) @(posedge ref_clk);
            end
            {hit_rate, live, armed} <= '0;
            rd(WIN_FLAGS, STATE_CTRL_ADDR);
        end
        stop_test();
    end
endmodule
